// [src/vsl_regs.vh]
// Constants for the access-support block: register map, fields, states
`ifndef VSL_REGS_VH
`define VSL_REGS_VH

// Register byte addresses
`define VSL_CTRL_ADDR   4'h0
`define VSL_STAT_ADDR   4'h4

// Control register fields
`define VSL_B_LATCH     0
`define VSL_B_MODE      1
`define VSL_B_PIPE      2
`define VSL_B_WDLY      3
`define VSL_BCFG_LO     4
`define VSL_BCFG_HI     6
`define VSL_GDLY_LO     7
`define VSL_GDLY_HI     8
`define VSL_B_DUAL      9
`define VSL_B_WAITEN    10
`define VSL_B_ACKEN     11
`define VSL_PRE_LO      12
`define VSL_PRE_HI      15
`define VSL_CTRL_RST    16'h2000

// Access sequencer states
`define VSL_S_IDLE      3'h0
`define VSL_S_PEND      3'h1
`define VSL_S_ROW       3'h2
`define VSL_S_WDLY      3'h3
`define VSL_S_COL       3'h4

// Grant latch delays in clock edges
`define VSL_GDLY_ONE    2'h1
`define VSL_GDLY_TWO    2'h2

// Strobe masks
`define VSL_ALL4        4'hf
`define VSL_LOW2        4'h3
`define VSL_HIGH2       4'hc
`define VSL_ONE         4'h1

`endif

// [src/vsl_access.v]
// Access-support logic: address latches, pipelining, strobe selection
`timescale 1ns/1ps
`include "vsl_regs.vh"

// How it works
// - A control bit picks latched addresses or always-transparent latches.
// - Mode 0: latch strobe rise opens latches, its fall captures the address.
// - Mode 1: latches stay open until the start strobe asserts and captures.
// - After capture, column step increments the latched column address.
// - Column step at all-ones column wraps the column address to zero.
// - During refresh, column step means refresh extend; host avoids that case.
// - Dual port: ungranted port A captures one or two edges after grant drops.
// - Port B captures on its request if granted, else edges after grant rises.
// - Pipelining returns row address after column hold, allowing a new start.
// - Pipelining only for port A and excludes column stepping modes.
// - Pipelined mode 0: wait asserts when latch strobe and chip select assert.
// - Pipelined: acknowledge negates with request; mode 1 wait follows start strobe.
// - Same-bank precharge or refresh still holds off a pipelined access.
// - Write column delay holds column strobe to the second edge after row strobe.
// - Without write column delay, reads and writes strobe columns alike.
// - Column strobes stay negated while their column-extend enables are negated.
// - Three config bits with bank selects pick row and column strobes.
// - All-column configuration: each extend input enables a strobe pair.
// - Each row strobe has its own precharge counter.
// - Mode 0 starts the row strobe next edge; mode 1 starts it at once.
module vsl_access (
    input  wire        i_clock,
    input  wire        i_reset_n,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [3:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    input  wire        i_ale,
    input  wire        i_access_start_strobe_n,
    input  wire        i_access_request_hold_n,
    input  wire        i_cs_n,
    input  wire [9:0]  i_row_addr,
    input  wire [9:0]  i_col_addr,
    input  wire [1:0]  i_bank_select_inputs,
    input  wire        i_column_step,
    input  wire        i_refresh_active_flag_n,
    input  wire        i_write_indicator_n,
    input  wire [1:0]  i_column_extend_enable_n,
    input  wire        i_second_port_request_n,
    input  wire        i_second_port_grant,
    output wire [3:0]  o_ras_n,
    output wire [3:0]  o_cas_n,
    output reg  [9:0]  o_mem_addr,
    output wire        o_wait,
    output reg         o_data_transfer_ack_n,
    output wire        o_refresh_extend
);

    localparam S_IDLE = `VSL_S_IDLE;
    localparam S_PEND = `VSL_S_PEND;
    localparam S_ROW  = `VSL_S_ROW;
    localparam S_WDLY = `VSL_S_WDLY;
    localparam S_COL  = `VSL_S_COL;

    reg  [15:0] ctrl;
    reg  [2:0]  st;
    reg  [2:0]  next_st;
    reg  [3:0]  cur_ras;
    reg  [3:0]  cur_cas;
    reg  [3:0]  old_ras;
    reg  [3:0]  old_cas;
    reg  [3:0]  ras_prev;
    reg         hold_ok;
    reg         pend;
    reg         ale_q;
    reg         ads_q;
    reg         access_request_hold_q;
    reg         reqb_q;
    reg         grant_q;
    reg         open;
    reg         next_open;
    reg         cap;
    reg  [9:0]  row_l;
    reg  [9:0]  col_l;
    reg  [1:0]  bank_l;
    reg         a_pend;
    reg         next_apend;
    reg  [1:0]  gcnt;
    reg  [1:0]  next_gcnt;
    reg  [3:0]  nm;

    // Control fields
    wire       lm      = ctrl[`VSL_B_LATCH];
    wire       mode1   = ctrl[`VSL_B_MODE];
    wire       wdly    = ctrl[`VSL_B_WDLY];
    wire [2:0] bcfg    = ctrl[`VSL_BCFG_HI:`VSL_BCFG_LO];
    wire [1:0] gdly    = ctrl[`VSL_GDLY_HI:`VSL_GDLY_LO];
    wire       dual    = ctrl[`VSL_B_DUAL];
    wire       wait_en = ctrl[`VSL_B_WAITEN];
    wire       ack_en  = ctrl[`VSL_B_ACKEN];
    wire [3:0] pre     = ctrl[`VSL_PRE_HI:`VSL_PRE_LO];

    // Pipelining is a port A feature only
    wire pipe = ctrl[`VSL_B_PIPE] & ~(dual & i_second_port_grant);

    // Input edges, inputs are synchronous
    wire ale_rise   = i_ale & ~ale_q;
    wire ale_fall   = ~i_ale & ale_q;
    wire ads_fall   = ~i_access_start_strobe_n & ads_q;
    wire access_request_hold_rise  = i_access_request_hold_n & ~access_request_hold_q;
    wire reqb_fall  = ~i_second_port_request_n & reqb_q;
    wire grant_rise = i_second_port_grant & ~grant_q;
    wire grant_fall = ~i_second_port_grant & grant_q;
    wire a_req_ev   = ~i_cs_n & (mode1 ? ads_fall : ale_rise);
    wire [1:0] gload = (gdly != 2'h0) ? `VSL_GDLY_TWO : `VSL_GDLY_ONE;

    // Address seen by the strobes: latched or falling through
    wire       held   = lm & ~open;
    wire [9:0] a_row  = held ? row_l : i_row_addr;
    wire [9:0] a_col  = held ? col_l : i_col_addr;
    wire [1:0] a_bank = held ? bank_l : i_bank_select_inputs;

    wire refresh = ~i_refresh_active_flag_n;
    wire step    = held & i_column_step & ~refresh & ~pipe;

    // Column step during refresh is a refresh extension
    assign o_refresh_extend = i_column_step & refresh;

    // Latch control decisions
    always @* begin
        cap = 1'b0;
        next_open = open;
        next_apend = a_pend;
        next_gcnt = (gcnt != 2'h0) ? gcnt - 2'h1 : 2'h0;
        if (!lm) begin
            next_open = 1'b1;
            next_apend = 1'b0;
            next_gcnt = 2'h0;
        end else if (dual && (i_second_port_grant || a_pend || gcnt != 2'h0)) begin
            if (gcnt == `VSL_GDLY_ONE) begin
                cap = 1'b1;
                next_open = 1'b0;
            end
            if (grant_rise) begin
                next_gcnt = gload;
            end
            if (i_second_port_grant && !grant_rise && reqb_fall) begin
                cap = 1'b1;
                next_open = 1'b0;
            end
            if (i_second_port_grant && a_req_ev) begin
                next_apend = 1'b1;
            end
            if (grant_fall && a_pend) begin
                next_gcnt = gload;
                next_apend = 1'b0;
            end
        end else if (!mode1) begin
            if (ale_rise) begin
                next_open = 1'b1;
            end else if (ale_fall) begin
                cap = 1'b1;
                next_open = 1'b0;
            end
        end else begin
            if (ads_fall) begin
                cap = 1'b1;
                next_open = 1'b0;
            end else if (access_request_hold_rise) begin
                next_open = 1'b1;
            end
        end
    end

    // Address latches and column counter
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            open <= 1'b1;
            row_l <= 10'h000;
            col_l <= 10'h000;
            bank_l <= 2'h0;
            a_pend <= 1'b0;
            gcnt <= 2'h0;
        end else begin
            open <= next_open;
            a_pend <= next_apend;
            gcnt <= next_gcnt;
            if (cap) begin
                row_l <= i_row_addr;
                col_l <= i_col_addr;
                bank_l <= i_bank_select_inputs;
            end else if (step) begin
                col_l <= col_l + 10'h001;
            end
        end
    end

    // Row strobe selection from configuration and bank
    always @* begin
        case (bcfg[1:0])
            2'h0: nm = `VSL_ALL4;
            2'h1: nm = a_bank[0] ? `VSL_HIGH2 : `VSL_LOW2;
            default: nm = `VSL_ONE << a_bank;
        endcase
    end

    // Column strobes: all with byte pairs, or follow row strobes
    wire [3:0] ncm = bcfg[2] ? `VSL_ALL4 : nm;
    wire [3:0] column_extend_enable_en = {{2{~i_column_extend_enable_n[1]}},
                          {2{~i_column_extend_enable_n[0]}}};

    // Per-line precharge counters
    wire [3:0] ras_on = cur_ras | old_ras;
    wire [3:0] busy;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pre
            reg [3:0] cnt;
            always @(posedge i_clock) begin
                if (!i_reset_n) begin
                    cnt <= 4'h0;
                end else if (ras_prev[gi] && !ras_on[gi]) begin
                    cnt <= pre;
                end else if (cnt != 4'h0) begin
                    cnt <= cnt - 4'h1;
                end
            end
            assign busy[gi] = (cnt != 4'h0) | (ras_prev[gi] & ~ras_on[gi]);
        end
    endgenerate

    // Start conditions
    wire start_ev = mode1 ? a_req_ev : 1'b0;
    wire slot_ok  = (st == S_IDLE) | (st == S_PEND) |
                    ((st == S_COL) & pipe & hold_ok & (old_ras == 4'h0));
    wire go = (pend | start_ev) & slot_ok & ~refresh & ~access_request_hold_rise &
              ((nm & (busy | ras_on)) == 4'h0);
    wire cas_due = ~(wdly & ~i_write_indicator_n);

    // Sequencer next state
    always @* begin
        next_st = st;
        case (st)
            S_IDLE: next_st = go ? S_ROW : (start_ev ? S_PEND : S_IDLE);
            S_PEND: next_st = go ? S_ROW : S_PEND;
            S_ROW: next_st = cas_due ? S_COL : S_WDLY;
            S_WDLY: next_st = S_COL;
            S_COL: next_st = go ? S_ROW : S_COL;
            default: next_st = S_IDLE;
        endcase
        if (access_request_hold_rise && old_ras == 4'h0 && st != S_IDLE && st != S_PEND) begin
            next_st = S_IDLE;
        end
    end

    // Sequencer registers and strobe masks
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            st <= S_IDLE;
            cur_ras <= 4'h0;
            cur_cas <= 4'h0;
            old_ras <= 4'h0;
            old_cas <= 4'h0;
            ras_prev <= 4'h0;
            hold_ok <= 1'b0;
            pend <= 1'b0;
            ale_q <= 1'b0;
            ads_q <= 1'b1;
            access_request_hold_q <= 1'b1;
            reqb_q <= 1'b1;
            grant_q <= 1'b0;
        end else begin
            ale_q <= i_ale;
            ads_q <= i_access_start_strobe_n;
            access_request_hold_q <= i_access_request_hold_n;
            reqb_q <= i_second_port_request_n;
            grant_q <= i_second_port_grant;
            ras_prev <= ras_on;
            st <= next_st;
            if (go) begin
                pend <= 1'b0;
            end else if (a_req_ev) begin
                pend <= 1'b1;
            end
            hold_ok <= (st == S_COL) & ~go;
            if (access_request_hold_rise && old_ras != 4'h0) begin
                old_ras <= 4'h0;
                old_cas <= 4'h0;
            end else if (go && st == S_COL) begin
                old_ras <= cur_ras;
                old_cas <= cur_cas;
            end
            if (go) begin
                cur_ras <= nm;
                cur_cas <= ncm;
            end else if (next_st == S_IDLE) begin
                cur_ras <= 4'h0;
                cur_cas <= 4'h0;
            end
        end
    end

    // Strobe outputs; extend enables gate the column strobes
    assign o_ras_n = ~ras_on;
    assign o_cas_n = ~((old_cas | (cur_cas & {4{st == S_COL}})) & column_extend_enable_en);

    // Wait: open access before its column strobe, or pipelined new start
    assign o_wait = wait_en & ((st == S_PEND) | (st == S_ROW) | (st == S_WDLY) |
                    (pipe & ~i_cs_n & (mode1 ? ~i_access_start_strobe_n : i_ale)));

    // Memory address and acknowledge registers
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_mem_addr <= 10'h000;
            o_data_transfer_ack_n <= 1'b1;
        end else begin
            if (st == S_ROW || st == S_WDLY || (st == S_COL && !(pipe && hold_ok))) begin
                o_mem_addr <= a_col;
            end else begin
                o_mem_addr <= a_row;
            end
            if (access_request_hold_rise) begin
                o_data_transfer_ack_n <= 1'b1;
            end else if (ack_en && next_st == S_COL && st != S_COL) begin
                o_data_transfer_ack_n <= 1'b0;
            end
        end
    end

    // Wishbone slave, one wait-free answer per request
    wire wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire [31:0] stat = {8'h00, st, open, bank_l, cur_ras, old_ras, col_l};
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            ctrl <= `VSL_CTRL_RST;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= wb_hit;
            if (wb_hit && i_wb_we && i_wb_adr == `VSL_CTRL_ADDR) begin
                if (i_wb_sel[0]) ctrl[7:0] <= i_wb_dat[7:0];
                if (i_wb_sel[1]) ctrl[15:8] <= i_wb_dat[15:8];
            end
            if (wb_hit && !i_wb_we) begin
                case (i_wb_adr)
                    `VSL_CTRL_ADDR: o_wb_dat <= {16'h0000, ctrl};
                    `VSL_STAT_ADDR: o_wb_dat <= stat;
                    default: o_wb_dat <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// [sim/vsl_access_sva.sv]
// Port checker for the access-support block
`timescale 1ns/1ps
module vsl_access_sva (
    input wire       i_clock,
    input wire       i_reset_n,
    input wire       i_wb_cyc,
    input wire       i_wb_stb,
    input wire       o_wb_ack,
    input wire       i_column_step,
    input wire       i_refresh_active_flag_n,
    input wire       i_access_request_hold_n,
    input wire [1:0] i_column_extend_enable_n,
    input wire [3:0] o_ras_n,
    input wire [3:0] o_cas_n,
    input wire       o_data_transfer_ack_n,
    input wire       o_refresh_extend
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    // Row strobes leave the all-idle state
    sequence s_ras_start;
        &o_ras_n ##1 !(&o_ras_n);
    endsequence
    AST_RESET_IDLE: assert property ($rose(i_reset_n) |-> &o_ras_n && &o_cas_n && o_data_transfer_ack_n)
        else $error("strobes not idle after reset");
    AST_WB_ANSWER: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request not answered next cycle");
    AST_WB_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("bus ack longer than one cycle");
    AST_EXT_LOW: assert property (i_column_extend_enable_n[0] |-> &o_cas_n[1:0])
        else $error("low column pair active while its enable is negated");
    AST_EXT_HIGH: assert property (i_column_extend_enable_n[1] |-> &o_cas_n[3:2])
        else $error("high column pair active while its enable is negated");
    AST_RFX_ON: assert property (i_column_step && !i_refresh_active_flag_n |-> o_refresh_extend)
        else $error("column step during refresh not taken as extend");
    AST_RFX_OFF: assert property (o_refresh_extend |-> i_column_step && !i_refresh_active_flag_n)
        else $error("refresh extend without its cause");
    AST_CAS_AFTER_RAS: assert property (s_ras_start |-> &o_cas_n)
        else $error("column strobe with row strobe start");
    AST_CAS_NEEDS_RAS: assert property (!(&o_cas_n) |-> !(&o_ras_n))
        else $error("column strobe without any row strobe");
    AST_ACK_ENDS: assert property ($rose(i_access_request_hold_n) |=> o_data_transfer_ack_n)
        else $error("transfer ack still low after request negated");
endmodule

bind vsl_access vsl_access_sva u_sva (.i_clock, .i_reset_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
    .i_column_step, .i_refresh_active_flag_n, .i_access_request_hold_n, .i_column_extend_enable_n,
    .o_ras_n, .o_cas_n, .o_data_transfer_ack_n, .o_refresh_extend);

// [sim/vsl_host_model.sv]
// Host bus model issuing port A accesses
`timescale 1ns/1ps
module vsl_host_model (
    input  wire       i_clock,
    input  wire       i_go,
    input  wire       i_mode,
    input  wire       i_write,
    input  wire [1:0] i_bank,
    input  wire [3:0] i_hold,
    input  wire [3:0] i_ras_n,
    input  wire [3:0] i_cas_n,
    output reg        o_ale = 1'b0,
    output reg        o_start_n = 1'b1,
    output reg        o_hold_n = 1'b1,
    output reg        o_cs_n = 1'b1,
    output reg        o_write_n = 1'b1,
    output reg  [1:0] o_bank = 2'h0,
    output reg        o_busy = 1'b0
);
    integer n;
    // One access for each go pulse
    always begin
        @(posedge i_clock);
        if (i_go) begin
            o_busy <= 1'b1;
            o_cs_n <= 1'b0;
            o_hold_n <= 1'b0;
            o_write_n <= !i_write;
            o_bank <= i_bank;
            o_ale <= !i_mode;
            o_start_n <= !i_mode;
            @(posedge i_clock);
            o_ale <= 1'b0;
            o_start_n <= 1'b1;
            n = 0;
            while (&i_cas_n && n < 30) begin
                @(posedge i_clock);
                n = n + 1;
            end
            repeat (i_hold) @(posedge i_clock);
            o_hold_n <= 1'b1;
            o_cs_n <= 1'b1;
            o_write_n <= 1'b1;
            o_bank <= ~o_bank; // Released lines do not keep their value
            n = 0;
            while (!(&i_ras_n) && n < 30) begin
                @(posedge i_clock);
                n = n + 1;
            end
            @(posedge i_clock);
            o_busy <= 1'b0;
        end
    end
endmodule

// [sim/vsl_access_tb_top.sv]
// Self-checking bench for the access-support block
`timescale 1ns/1ps
`include "vsl_regs.vh"
module vsl_access_tb_top;
    reg         i_clock = 1'b0;
    reg         i_reset_n = 1'b0;
    reg         wb_cyc = 1'b0;
    reg         wb_we = 1'b0;
    reg  [3:0]  wb_adr = 4'h0;
    reg  [31:0] wb_wdat = 32'h0;
    reg  [31:0] q;
    reg  [9:0]  row = 10'h0;
    reg  [9:0]  col = 10'h0;
    reg         step = 1'b0;
    reg         refresh_n = 1'b1;
    reg  [1:0]  ext_n = 2'h0;
    reg         go = 1'b0;
    reg         mode = 1'b1;
    reg         wr = 1'b0;
    reg  [1:0]  bank = 2'h0;
    reg  [3:0]  hold_len = 4'h4;
    wire [31:0] wb_rdat;
    wire        wb_ack;
    wire        ale;
    wire        start_n;
    wire        hold_n;
    wire        cs_n;
    wire        write_n;
    wire        busy;
    wire [1:0]  bsel;
    wire [3:0]  ras_n;
    wire [3:0]  cas_n;
    wire [9:0]  maddr;
    wire        ack_n;
    wire        rfx;
    wire        wt;
    integer     failures = 0;
    integer     compares = 0;
    integer     i;

    vsl_access u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_cyc),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hf), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat),
        .o_wb_ack(wb_ack), .i_ale(ale), .i_access_start_strobe_n(start_n), .i_access_request_hold_n(hold_n),
        .i_cs_n(cs_n), .i_row_addr(row), .i_col_addr(col), .i_bank_select_inputs(bsel), .i_column_step(step),
        .i_refresh_active_flag_n(refresh_n), .i_write_indicator_n(write_n), .i_column_extend_enable_n(ext_n),
        .i_second_port_request_n(1'b1), .i_second_port_grant(1'b0), .o_ras_n(ras_n), .o_cas_n(cas_n),
        .o_mem_addr(maddr), .o_wait(wt), .o_data_transfer_ack_n(ack_n), .o_refresh_extend(rfx));

    vsl_host_model u_host (.i_clock(i_clock), .i_go(go), .i_mode(mode), .i_write(wr), .i_bank(bank),
        .i_hold(hold_len), .i_ras_n(ras_n), .i_cas_n(cas_n), .o_ale(ale), .o_start_n(start_n),
        .o_hold_n(hold_n), .o_cs_n(cs_n), .o_write_n(write_n), .o_bank(bsel), .o_busy(busy));

    // Clock
    initial begin
        forever #10 i_clock = ~i_clock;
    end

    task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task results;
        begin
            if (failures == 0 && compares > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // Control word: wait and ack enabled, precharge 2
    function [31:0] cw(input l, input m, input d, input [2:0] g);
        cw = {16'h0, 4'h2, 2'b11, 3'b000, g, d, 1'b0, m, l};
    endfunction

    task wb(input w, input [3:0] a, input [31:0] d, output [31:0] r);
        integer n;
        begin
            wb_cyc <= 1'b1;
            wb_we <= w;
            wb_adr <= a;
            wb_wdat <= d;
            n = 0;
            @(posedge i_clock);
            while (wb_ack !== 1'b1 && n < 20) begin
                @(posedge i_clock);
                n = n + 1;
            end
            if (wb_ack !== 1'b1)
                failures = failures + 1; // Bus answer never came
            r = wb_rdat;
            wb_cyc <= 1'b0;
            @(posedge i_clock);
        end
    endtask

    task acc(input m, input w, input [1:0] b, input [9:0] c, input [3:0] er, input [3:0] ec,
             input [3:0] gap, input [9:0] ea);
        integer n, rs, cs;
        begin
            n = 0;
            while (busy !== 1'b0 && n < 60) begin
                @(posedge i_clock);
                n = n + 1;
            end
            col <= c;
            mode <= m;
            wr <= w;
            bank <= b;
            go <= 1'b1;
            rs = 0;
            cs = 0;
            for (n = 1; n < 12; n = n + 1) begin
                @(posedge i_clock);
                go <= 1'b0;
                if (n == 3)
                    col <= 10'h15a; // Moves after capture
                if (rs == 0 && !(&ras_n)) begin
                    rs = n;
                    check(wt, 1, "wait_row");
                end
                if (cs == 0 && !(&cas_n)) begin
                    cs = n;
                    check(wt, 0, "wait_col");
                    check(ras_n, er, "row_sel");
                    check(cas_n, ec, "col_sel");
                    check(ack_n, 0, "xfer_ack");
                end
                if (cs != 0 && n == cs + 2)
                    check(maddr, ea, "mem_addr");
            end
            check(cs - rs, gap, "cas_gap");
        end
    endtask

    task t_regs;
        begin
            wb(1'b0, `VSL_CTRL_ADDR, 32'h0, q);
            check(q, {16'h0, `VSL_CTRL_RST}, "ctrl_rst");
            wb(1'b1, `VSL_CTRL_ADDR, 32'hffff_2c21, q);
            wb(1'b0, `VSL_CTRL_ADDR, 32'h0, q);
            check(q, 32'h0000_2c21, "ctrl_rw");
            wb(1'b0, 4'h8, 32'h0, q);
            check(q, 32'h0, "unmapped");
        end
    endtask

    task t_refresh;
        begin
            refresh_n <= 1'b0;
            step <= 1'b1;
            @(posedge i_clock);
            @(posedge i_clock);
            check(rfx, 1, "rfx_on");
            refresh_n <= 1'b1;
            step <= 1'b0;
            @(posedge i_clock);
            @(posedge i_clock);
            check(rfx, 0, "rfx_off");
        end
    endtask

    task t_banks;
        begin
            wb(1'b1, `VSL_CTRL_ADDR, cw(1'b1, 1'b1, 1'b1, 3'h2), q);
            for (i = 0; i < 4; i = i + 1)
                acc(1'b1, 1'b0, i[1:0], 10'h2a5, ~(4'h1 << i), ~(4'h1 << i), 4'h1, 10'h2a5);
        end
    endtask

    task t_write_delay;
        begin
            acc(1'b1, 1'b1, 2'h0, 10'h2a5, 4'he, 4'he, 4'h2, 10'h2a5);
            wb(1'b1, `VSL_CTRL_ADDR, cw(1'b1, 1'b1, 1'b0, 3'h2), q);
            acc(1'b1, 1'b1, 2'h1, 10'h2a5, 4'hd, 4'hd, 4'h1, 10'h2a5);
        end
    endtask

    task t_latch;
        begin
            wb(1'b1, `VSL_CTRL_ADDR, cw(1'b0, 1'b1, 1'b0, 3'h2), q);
            acc(1'b1, 1'b0, 2'h2, 10'h2a5, 4'hb, 4'hb, 4'h1, 10'h15a);
            wb(1'b1, `VSL_CTRL_ADDR, cw(1'b1, 1'b0, 1'b0, 3'h2), q);
            acc(1'b0, 1'b0, 2'h3, 10'h2a5, 4'h7, 4'h7, 4'h1, 10'h2a5);
        end
    endtask

    task t_extend;
        begin
            wb(1'b1, `VSL_CTRL_ADDR, cw(1'b1, 1'b1, 1'b0, 3'h4), q);
            ext_n <= 2'b10;
            acc(1'b1, 1'b0, 2'h0, 10'h2a5, 4'h0, 4'hc, 4'h1, 10'h2a5);
            ext_n <= 2'b00;
        end
    endtask

    task t_step;
        reg [9:0] c;
        begin
            wb(1'b1, `VSL_CTRL_ADDR, cw(1'b1, 1'b1, 1'b0, 3'h2), q);
            hold_len <= 4'hf;
            for (i = 0; i < 2; i = i + 1) begin
                c = (i == 0) ? 10'h3ff : 10'h2a5;
                acc(1'b1, 1'b0, i[1:0], c, ~(4'h1 << i), ~(4'h1 << i), 4'h1, c);
                step <= 1'b1;
                @(posedge i_clock);
                step <= 1'b0;
                wb(1'b0, `VSL_STAT_ADDR, 32'h0, q);
                check({22'h0, q[9:0]}, {22'h0, c + 10'h1}, "step_col");
            end
            hold_len <= 4'h4;
        end
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        t_regs;
        t_refresh;
        t_banks;
        t_write_delay;
        t_latch;
        t_extend;
        t_step;
        results;
    end

    // Cuts a hung run short
    initial begin
        #120000;
        failures = failures + 1;
        results;
    end
endmodule
